// File: pkg/rtc_serial_pkg.sv
// shared constants, types and encodings for the rtc two-wire target
// Overview of operation
// - read/write bit after device code picks mode
// - device acks each received byte on ninth clock while the register has room
// - read bytes shift out msb first
// - master nack ends read, device releases line
// - select bit picks status register one or two
// - select bit picks line a or b data
// - alarm mode makes data three bytes, else one
// - frequency mode byte holds frequency setting
// - abandoned transfer keeps state until stop or start
// - valid stop returns interface to idle
// - stop ignored while device drives line low
// - start ignored while device drives line low
// - recovery clocks finish output, then release line
package rtc_serial_pkg;

  // device code, arbitrary value
  localparam logic [3:0] DEV_CODE      = 4'ha;

  // address byte layout: code, group, select, direction
  localparam int         ADR_DEV_LSB   = 4;
  localparam int         ADR_GRP_LSB   = 2;
  localparam int         ADR_SEL_BIT   = 1;
  localparam int         ADR_RW_BIT    = 0;
  localparam logic [1:0] GRP_STATUS    = 2'h0;
  localparam logic [1:0] GRP_INTD      = 2'h2;

  // byte storage
  localparam int         NUM_BYTES     = 10;
  localparam int         BYTE_W        = 8;
  localparam int         IDX_W         = 4;
  localparam logic [3:0] IDX_ST1       = 4'h0;
  localparam logic [3:0] IDX_ST2       = 4'h1;
  localparam logic [3:0] IDX_INTA      = 4'h2;
  localparam logic [3:0] IDX_INTB      = 4'h5;
  localparam logic [3:0] IDX_AUX0      = 4'h8;
  localparam logic [3:0] IDX_AUX1      = 4'h9;
  localparam logic [7:0] RST_BYTE      = 8'h00;

  // status register two: interrupt line modes
  localparam int         ST2_MODEA_LSB = 0;
  localparam int         ST2_MODEB_LSB = 2;
  localparam logic [1:0] MODE_ALARM    = 2'h1;
  localparam logic [1:0] MODE_FREQ     = 2'h2;
  localparam logic [1:0] LEN_ALARM     = 2'h3;
  localparam logic [1:0] LEN_ONE       = 2'h1;

  // bit counting on the link
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;
  localparam logic       SDA_LOW       = 1'b0;

  // wishbone byte offsets
  localparam int         WB_AW         = 8;
  localparam logic [7:0] OFF_ST1       = 8'h00;
  localparam logic [7:0] OFF_ST2       = 8'h04;
  localparam logic [7:0] OFF_INTA      = 8'h08;
  localparam logic [7:0] OFF_INTB      = 8'h0c;
  localparam logic [7:0] OFF_AUX       = 8'h10;
  localparam logic [7:0] OFF_LINK      = 8'h14;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_ACK   = 3'b011,
    S_WRITE = 3'b010,
    S_READ  = 3'b110,
    S_RACK  = 3'b111,
    S_HOLD  = 3'b101
  } link_state_t;

  typedef struct packed {
    logic                 en;
    logic [IDX_W-1:0]     idx;
    logic [BYTE_W-1:0]    data;
  } ser_wr_t;

  typedef struct packed {
    logic                 rd;
    logic [1:0]           cnt;
    logic                 drv;
    link_state_t          st;
  } link_stat_t;

endpackage : rtc_serial_pkg

// File: rtl/line_sync.sv
// two-flop synchroniser for the link pins
module line_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // pins and synchronised copy
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // idle bus level is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= {W{1'b1}};
      q_o    <= {W{1'b1}};
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : line_sync

// File: rtl/reg_bank.sv
// byte storage with a serial write port and wishbone byte writes
module reg_bank
  import rtc_serial_pkg::*;
(
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // serial write port
  input  wire ser_wr_t                     ser_wr_i,
  // bus write port
  input  wire logic [NUM_BYTES-1:0]        wb_we_i,
  input  wire logic [NUM_BYTES*BYTE_W-1:0] wb_wd_i,
  // storage contents
  output logic      [NUM_BYTES*BYTE_W-1:0] bytes_o
);

  logic [BYTE_W-1:0] mem_q [NUM_BYTES];

  // serial write wins over a bus write to the same byte
  for (genvar i = 0; i < NUM_BYTES; i++) begin : g_byte
    wire ser_hit = ser_wr_i.en && (ser_wr_i.idx == IDX_W'(i));
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mem_q[i] <= RST_BYTE;
      end else if (ser_hit) begin
        mem_q[i] <= ser_wr_i.data;
      end else if (wb_we_i[i]) begin
        mem_q[i] <= wb_wd_i[i*BYTE_W +: BYTE_W];
      end
    end
    assign bytes_o[i*BYTE_W +: BYTE_W] = mem_q[i];
  end

endmodule : reg_bank

// File: rtl/rtc_serial_target.sv
// two-wire serial target of the rtc with wishbone register access
module rtc_serial_target
  import rtc_serial_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // two-wire link
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o
);

  localparam int BW = NUM_BYTES * BYTE_W;

  // byte picked out of the flattened storage
  function automatic logic [BYTE_W-1:0] byte_at(
    input logic [BW-1:0]    v,
    input logic [IDX_W-1:0] i
  );
    byte_at = v[i*BYTE_W +: BYTE_W];
  endfunction : byte_at

  // first storage byte of a command
  function automatic logic [IDX_W-1:0] cmd_base(
    input logic [1:0] grp,
    input logic       sel
  );
    case (grp)
      GRP_STATUS: cmd_base = sel ? IDX_ST2 : IDX_ST1;
      GRP_INTD:   cmd_base = sel ? IDX_INTB : IDX_INTA;
      default:    cmd_base = sel ? IDX_AUX1 : IDX_AUX0;
    endcase
  endfunction : cmd_base

  // bytes in a command's register, from status two
  function automatic logic [1:0] cmd_len(
    input logic [1:0]        grp,
    input logic              sel,
    input logic [BYTE_W-1:0] st2
  );
    logic [1:0] mode;
    mode = sel ? st2[ST2_MODEB_LSB +: 2] : st2[ST2_MODEA_LSB +: 2];
    if (grp == GRP_INTD && mode == MODE_ALARM) begin
      cmd_len = LEN_ALARM;
    end else begin
      cmd_len = LEN_ONE;
    end
  endfunction : cmd_len

  // word offset match, low two address bits ignored
  function automatic logic off_hit(
    input logic [WB_AW-1:0] a,
    input logic [WB_AW-1:0] off
  );
    off_hit = a[WB_AW-1:2] == off[WB_AW-1:2];
  endfunction : off_hit

  // ---- pin synchronisation and edge detection ----
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_p_q;
  logic       sda_p_q;

  line_sync #(
    .W (2)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({scl_i, sda_i}),
    .q_o   (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  logic sda_oe_q;
  logic sda_out_q;

  wire scl_rise   = scl_s & ~scl_p_q;
  wire scl_fall   = ~scl_s & scl_p_q;
  wire scl_high   = scl_s & scl_p_q;
  // own low drive masks both conditions
  wire start_cond = scl_high & sda_p_q & ~sda_s & ~sda_oe_q;
  wire stop_cond  = scl_high & ~sda_p_q & sda_s & ~sda_oe_q;

  // ---- link state ----
  link_state_t       state_q;
  link_state_t       state_d;
  logic [BYTE_W-1:0] shift_q;
  logic [BYTE_W-1:0] shift_d;
  logic [3:0]        bit_q;
  logic [3:0]        bit_d;
  logic [1:0]        cnt_q;
  logic [1:0]        cnt_d;
  logic [1:0]        len_q;
  logic [1:0]        len_d;
  logic [IDX_W-1:0]  base_q;
  logic [IDX_W-1:0]  base_d;
  logic              rd_q;
  logic              rd_d;
  logic              mack_q;
  logic              mack_d;
  logic              oe_d;

  logic [BW-1:0]     bytes_w;
  ser_wr_t           ser_wr;

  wire [1:0]        adr_grp  = shift_q[ADR_GRP_LSB +: 2];
  wire              adr_sel  = shift_q[ADR_SEL_BIT];
  wire              dev_hit  = shift_q[BYTE_W-1:ADR_DEV_LSB] == DEV_CODE;
  wire              byte_end = scl_fall && (bit_q == BYTE_BITS);
  wire [1:0]        cnt_inc  = cnt_q + 2'h1;
  wire              more_rd  = cnt_inc < len_q;
  wire              room_wr  = cnt_q < len_q;
  wire [IDX_W-1:0]  cur_idx  = base_q + {2'b00, cnt_q};
  wire [IDX_W-1:0]  nxt_idx  = base_q + {2'b00, cnt_inc};
  wire [BYTE_W-1:0] rd_cur   = byte_at(bytes_w, cur_idx);
  wire [BYTE_W-1:0] rd_nxt   = byte_at(bytes_w, nxt_idx);
  wire [BYTE_W-1:0] st2_now  = byte_at(bytes_w, IDX_ST2);

  // received byte goes to storage while it fits
  assign ser_wr.en   = (state_q == S_WRITE) && byte_end && room_wr && !stop_cond;
  assign ser_wr.idx  = cur_idx;
  assign ser_wr.data = shift_q;

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bit_d   = bit_q;
    cnt_d   = cnt_q;
    len_d   = len_q;
    base_d  = base_q;
    rd_d    = rd_q;
    mack_d  = mack_q;
    oe_d    = sda_oe_q;
    if (stop_cond) begin
      state_d = S_IDLE;
      oe_d    = 1'b0;
    end else if (start_cond) begin
      state_d = S_ADDR;
      bit_d   = '0;
    end else begin
      // no stop or start seen: state steps per the case below
      case (state_q)
        // refused or finished: wait for stop or start
        S_IDLE, S_HOLD: begin
          oe_d = 1'b0;
        end
        S_ADDR, S_WRITE: begin
          if (scl_rise && bit_q != BYTE_BITS) begin
            shift_d = {shift_q[BYTE_W-2:0], sda_s};
            bit_d   = bit_q + 4'h1;
          end else if (byte_end) begin
            if (state_q == S_ADDR && dev_hit) begin
              rd_d    = shift_q[ADR_RW_BIT];
              base_d  = cmd_base(adr_grp, adr_sel);
              // length latched now; later status writes do not resize
              len_d   = cmd_len(adr_grp, adr_sel, st2_now);
              cnt_d   = '0;
              oe_d    = 1'b1;
              state_d = S_ACK;
            end else if (state_q == S_WRITE && room_wr) begin
              cnt_d   = cnt_inc;
              oe_d    = 1'b1;
              state_d = S_ACK;
            end else begin
              state_d = S_HOLD;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            bit_d = '0;
            // first read bit goes out at the ack fall
            if (rd_q) begin
              shift_d = rd_cur;
              oe_d    = ~rd_cur[BYTE_W-1];
              state_d = S_READ;
            end else begin
              oe_d    = 1'b0;
              state_d = S_WRITE;
            end
          end
        end
        S_READ: begin
          if (scl_fall) begin
            if (bit_q == LAST_BIT) begin
              // eighth fall hands the ack slot to the master
              oe_d    = 1'b0;
              state_d = S_RACK;
            end else begin
              shift_d = {shift_q[BYTE_W-2:0], 1'b0};
              oe_d    = ~shift_q[BYTE_W-2];
              bit_d   = bit_q + 4'h1;
            end
          end
        end
        S_RACK: begin
          // master ack sampled at the rise, acted on at the fall
          if (scl_rise) begin
            mack_d = ~sda_s;
          end else if (scl_fall) begin
            bit_d = '0;
            if (mack_q && more_rd) begin
              cnt_d   = cnt_inc;
              shift_d = rd_nxt;
              oe_d    = ~rd_nxt[BYTE_W-1];
              state_d = S_READ;
            end else begin
              oe_d    = 1'b0;
              state_d = S_HOLD;
            end
          end
        end
        default: begin
          oe_d    = 1'b0;
          state_d = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= S_IDLE;
      shift_q   <= '0;
      bit_q     <= '0;
      cnt_q     <= '0;
      len_q     <= LEN_ONE;
      base_q    <= IDX_ST1;
      rd_q      <= 1'b0;
      mack_q    <= 1'b0;
      sda_oe_q  <= 1'b0;
      sda_out_q <= SDA_LOW;
    end else begin
      state_q   <= state_d;
      shift_q   <= shift_d;
      bit_q     <= bit_d;
      cnt_q     <= cnt_d;
      len_q     <= len_d;
      base_q    <= base_d;
      rd_q      <= rd_d;
      mack_q    <= mack_d;
      sda_oe_q  <= oe_d;
      sda_out_q <= SDA_LOW;
    end
  end

  // open drain: level fixed low, the enable signals
  assign sda_o    = sda_out_q;
  assign sda_oe_o = sda_oe_q;

  // ---- wishbone slave ----
  logic                 ack_q;
  logic [31:0]          dat_q;
  logic [NUM_BYTES-1:0] wb_we;
  logic [BW-1:0]        wb_wd;
  link_stat_t           link_stat;

  wire       req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire       wr_req   = req & wb_we_i;
  wire       hit_st1  = off_hit(wb_adr_i, OFF_ST1);
  wire       hit_st2  = off_hit(wb_adr_i, OFF_ST2);
  wire       hit_inta = off_hit(wb_adr_i, OFF_INTA);
  wire       hit_intb = off_hit(wb_adr_i, OFF_INTB);
  wire       hit_aux  = off_hit(wb_adr_i, OFF_AUX);
  wire       hit_link = off_hit(wb_adr_i, OFF_LINK);

  // mirrored lanes let one word fill any multi-byte register
  assign wb_wd = {wb_dat_i[15:0], {2{wb_dat_i[23:0]}}, {2{wb_dat_i[7:0]}}};

  assign wb_we = {NUM_BYTES{wr_req}} & {
    hit_aux  & wb_sel_i[1], hit_aux  & wb_sel_i[0],
    hit_intb & wb_sel_i[2], hit_intb & wb_sel_i[1], hit_intb & wb_sel_i[0],
    hit_inta & wb_sel_i[2], hit_inta & wb_sel_i[1], hit_inta & wb_sel_i[0],
    hit_st2  & wb_sel_i[0], hit_st1  & wb_sel_i[0]
  };

  assign link_stat.rd  = rd_q;
  assign link_stat.cnt = cnt_q;
  assign link_stat.drv = sda_oe_q;
  assign link_stat.st  = state_q;

  // read words per offset, unused upper lanes zero
  wire [31:0] rd_st1  = 32'(byte_at(bytes_w, IDX_ST1));
  wire [31:0] rd_st2  = 32'(st2_now);
  wire [31:0] rd_inta = 32'(bytes_w[IDX_INTA*BYTE_W +: 3*BYTE_W]);
  wire [31:0] rd_intb = 32'(bytes_w[IDX_INTB*BYTE_W +: 3*BYTE_W]);
  wire [31:0] rd_aux  = 32'(bytes_w[IDX_AUX0*BYTE_W +: 2*BYTE_W]);
  wire [31:0] rd_link = 32'(link_stat);

  wire [31:0] rdata =
    hit_st1  ? rd_st1  :
    hit_st2  ? rd_st2  :
    hit_inta ? rd_inta :
    hit_intb ? rd_intb :
    hit_aux  ? rd_aux  :
    hit_link ? rd_link : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= req ? rdata : dat_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  reg_bank u_bank (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ser_wr_i (ser_wr),
    .wb_we_i  (wb_we),
    .wb_wd_i  (wb_wd),
    .bytes_o  (bytes_w)
  );

endmodule : rtc_serial_target

// File: verif/rtc_serial_target_sva.sv
// port assertions for the rtc two-wire target
module rtc_serial_target_sva
  import rtc_serial_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // link
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing after request");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");

  property p_ack_cause;
    wb_ack_o |-> $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without strobe");

  property p_dat_hold;
    $changed(wb_dat_o) |-> wb_ack_o;
  endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data moved without ack");

  property p_sda_zero;
    sda_oe_o |-> sda_o == SDA_LOW;
  endproperty
  a_sda_zero: assert property (p_sda_zero)
    else $error("driven data line not low");

  // drive changes only a few clocks after a serial clock fall
  property p_oe_fall;
    $changed(sda_oe_o) |-> !scl_i &&
      ($past(scl_i, 2) || $past(scl_i, 3) || $past(scl_i, 4) || $past(scl_i, 5));
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("drive changed away from clock fall");

  property p_oe_hold;
    scl_i && $past(scl_i) && $past(scl_i, 2) |=> $stable(sda_oe_o);
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("drive changed while clock high");

  property p_stop_idle;
    scl_i && $past(scl_i) && $rose(sda_i) && !sda_oe_o |=> !sda_oe_o [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("drive after stop");
endmodule : rtc_serial_target_sva

bind rtc_serial_target rtc_serial_target_sva u_sva (
  .clk_i    (clk_i),
  .rst_i    (rst_i),
  .wb_cyc_i (wb_cyc_i),
  .wb_stb_i (wb_stb_i),
  .wb_dat_o (wb_dat_o),
  .wb_ack_o (wb_ack_o),
  .scl_i    (scl_i),
  .sda_i    (sda_i),
  .sda_o    (sda_o),
  .sda_oe_o (sda_oe_o)
);

// File: verif/two_wire_master.sv
// behavioural two-wire bus master for the link
module two_wire_master (
  // clock
  input  wire logic       clk_i,
  // open-drain link, 1 releases
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            sda_o,
  // one result per byte: data, ack slot
  output logic [8:0]      res_o,
  output logic            res_vld_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    res_o = 9'h000;
    res_vld_o = 1'b0;
  end

  // quarter bit of 5 clocks, 80 ns a bit
  task automatic step(input logic c, input logic d);
    scl_o <= c;
    sda_o <= d;
    repeat (5) @(posedge clk_i);
  endtask : step

  task automatic bit_x(input logic b, output logic r);
    step(1'b0, b);
    step(1'b1, b);
    r = sda_i;
    step(1'b1, b);
    step(1'b0, b);
  endtask : bit_x

  task automatic start_c();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start_c

  task automatic stop_c();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop_c

  // byte out or in; m_ack high leaves the ack slot released
  task automatic xbyte(input logic [7:0] d, input logic m_ack);
    logic [8:0] r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i+1]);
    end
    bit_x(m_ack, r[0]);
    res_o <= r;
    res_vld_o <= 1'b1;
    @(posedge clk_i);
    res_vld_o <= 1'b0;
  endtask : xbyte

  // stuck-bus recovery with released data line
  task automatic recover();
    logic r;
    start_c();
    repeat (63) bit_x(1'b1, r);
    stop_c();
  endtask : recover
endmodule : two_wire_master

// File: verif/tb.sv
// self-checking bench for the rtc two-wire target
module tb
  import rtc_serial_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, cyc, stb, we, ack, scl, sda_m, sda_d, sda_oe, res_vld;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] lfsr_q;
  logic [8:0]  res;
  logic [63:0] mon_n;
  logic [63:0] exp_q[$];
  int          error_cnt;
  int          tests_run;
  int          cyc_cnt;
  wire logic   sda = sda_m & ~(sda_oe & ~sda_d);

  rtc_serial_target u_dut (
    .clk_i    (clk),
    .rst_i    (rst),
    .wb_cyc_i (cyc),
    .wb_stb_i (stb),
    .wb_we_i  (we),
    .wb_adr_i (adr),
    .wb_sel_i (sel),
    .wb_dat_i (wdat),
    .wb_dat_o (rdat),
    .wb_ack_o (ack),
    .scl_i    (scl),
    .sda_i    (sda),
    .sda_o    (sda_d),
    .sda_oe_o (sda_oe)
  );

  two_wire_master u_mst (
    .clk_i     (clk),
    .sda_i     (sda),
    .scl_o     (scl),
    .sda_o     (sda_m),
    .res_o     (res),
    .res_vld_o (res_vld)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[7:0];
  endfunction : rnd

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wb_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    wb(1'b0, a, 32'h0);
  endtask : wb_rd

  task automatic lk(input logic [7:0] d, input logic a, input logic [8:0] e);
    exp_q.push_back({32'h1ff, 23'h0, e});
    u_mst.xbyte(d, a);
  endtask : lk

  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      mon_n = exp_q.pop_front();
      chk("wb_dat_o", rdat & mon_n[63:32], mon_n[31:0]);
    end
    if (res_vld === 1'b1) begin
      mon_n = exp_q.pop_front();
      chk("link", {23'h0, res}, mon_n[31:0]);
    end
  end

  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    logic [7:0] d[3];
    logic [7:0] f;
    logic       l;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    rst = 1'b1;
    lfsr_q = 32'h53b39fb3;
    error_cnt = 0;
    tests_run = 0;
    cyc_cnt = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    wb_rd(OFF_ST2, 32'h0, 32'hffffffff);
    wb_rd(OFF_LINK, 32'h0, 32'hf);
    wb(1'b1, 8'h18, 32'hffffffff);
    wb_rd(8'h18, 32'h0, 32'hffffffff);
    u_mst.recover();
    wb_rd(OFF_LINK, 32'h0, 32'hf);
    $display("test reset done");
    // status pair by select bit, line a in alarm mode only
    f = rnd();
    wb(1'b1, OFF_ST1, {24'h0, f});
    wb(1'b1, OFF_ST2, 32'h1);
    u_mst.start_c();
    lk(8'ha1, 1'b1, {8'ha1, 1'b0});
    lk(8'hff, 1'b1, {f, 1'b1});
    u_mst.start_c();
    lk(8'ha3, 1'b1, {8'ha3, 1'b0});
    lk(8'hff, 1'b1, {8'h01, 1'b1});
    u_mst.stop_c();
    $display("test select done");
    // three-byte alarm block, fourth byte refused
    u_mst.start_c();
    lk(8'ha8, 1'b1, {8'ha8, 1'b0});
    for (int i = 0; i < 3; i++) begin
      d[i] = rnd();
      lk(d[i], 1'b1, {d[i], 1'b0});
    end
    lk(8'h5a, 1'b1, {8'h5a, 1'b1});
    u_mst.stop_c();
    wb_rd(OFF_INTA, {8'h0, d[2], d[1], d[0]}, 32'hffffffff);
    wb_rd(OFF_INTB, 32'h0, 32'hffffffff);
    u_mst.start_c();
    lk(8'ha9, 1'b1, {8'ha9, 1'b0});
    for (int i = 0; i < 3; i++) begin
      l = (i == 2);
      lk(8'hff, l, {d[i], l});
    end
    u_mst.stop_c();
    wb_rd(OFF_LINK, 32'h0, 32'hf);
    $display("test alarm block done");
    // line b as one-byte frequency setting
    wb(1'b1, OFF_ST2, 32'h8);
    f = rnd();
    u_mst.start_c();
    lk(8'haa, 1'b1, {8'haa, 1'b0});
    lk(f, 1'b1, {f, 1'b0});
    lk(f, 1'b1, {f, 1'b1});
    u_mst.stop_c();
    wb_rd(OFF_INTB, {24'h0, f}, 32'hffffffff);
    $display("test frequency done");
    // aux byte by select, foreign device code left unacked
    f = rnd();
    u_mst.start_c();
    lk(8'ha6, 1'b1, {8'ha6, 1'b0});
    lk(f, 1'b1, {f, 1'b0});
    u_mst.start_c();
    lk(8'h51, 1'b1, {8'h51, 1'b1});
    u_mst.stop_c();
    wb_rd(OFF_AUX, {16'h0, f, 8'h00}, 32'hffffffff);
    $display("test aux done");
    // abandoned read: stop ignored while pulled low, then recovery
    u_mst.start_c();
    lk(8'ha3, 1'b1, {8'ha3, 1'b0});
    u_mst.stop_c();
    chk("sda", {31'h0, sda}, 32'h0);
    u_mst.recover();
    wb_rd(OFF_LINK, 32'h0, 32'hf);
    u_mst.start_c();
    lk(8'ha3, 1'b1, {8'ha3, 1'b0});
    lk(8'hff, 1'b1, {8'h08, 1'b1});
    u_mst.stop_c();
    $display("test recovery done");
    tally_and_finish();
  end
endmodule : tb
